// >>> design/fir_dec_map.vh
`ifndef FIR_DEC_MAP_VH
`define FIR_DEC_MAP_VH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define CELL_COUNT        8
`define CELL_SEL_WIDTH    3
`define COEF_WIDTH        9
`define RESULT_WIDTH      26
`define DEC_SEL_WIDTH     2

// ----------------------------------------------------------------
// result bus lanes
// ----------------------------------------------------------------
`define RESULT_LOW_MSB    15
`define RESULT_HIGH_LSB   16
`define RESULT_HIGH_MSB   25

// ----------------------------------------------------------------
// decimation select codes
// ----------------------------------------------------------------
`define DEC_NONE          2'h0
`define DEC_ONE           2'h1
`define DEC_TWO           2'h2
`define DEC_THREE         2'h3

// ----------------------------------------------------------------
// result buffer
// ----------------------------------------------------------------
`define RESULT_FIFO_DEPTH 8
`define RESULT_FIFO_AW    3

`endif

// >>> design/fir_decimation_and_result_bus.v
`timescale 1ns/100ps
`default_nettype none
`include "fir_dec_map.vh"

// ----------------------------------------------------------------
// result buffer fifo
// ----------------------------------------------------------------
module result_fifo #(
   parameter WIDTH = `RESULT_WIDTH,
   parameter DEPTH = `RESULT_FIFO_DEPTH,
   parameter AW    = `RESULT_FIFO_AW
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr_r;
   reg  [AW-1:0]    rd_ptr_r;
   reg  [AW:0]      count_r;
   wire             push;
   wire             pop;

   assign in_ready  = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule // result_fifo

// Operation
// - decimation select picks zero to three registers
// - coefficients advance slower with more decimation registers
// - decimation select is latched, one clock late
// - drive 26-bit result from cell or adder
// - cell select chooses one of eight cells
// - shift-add select picks cell or adder result
// - upper enable low drives bits 16 to 25
// - lower enable low drives bits 0 to 15
// - decimation adds one to three clocks delay
// - latched cell select holds first selected result
// - shift-add select reaches the result bus four clocks late
module fir_decimation_and_result_bus #(
   parameter CELLS = `CELL_COUNT,
   parameter CW    = `COEF_WIDTH,
   parameter RW    = `RESULT_WIDTH
) (
   input  wire                CLOCK,
   input  wire                RSTN,
   input  wire [CW-1:0]       COEFFICIENT_IN,
   input  wire                COEFFICIENT_LOAD_ENABLE_N,
   input  wire [1:0]          DECIMATION_SELECT,
   input  wire [2:0]          CELL_SELECT,
   input  wire                SHIFT_ADD_SELECT,
   input  wire                RESULT_UPPER_ENABLE_N,
   input  wire                RESULT_LOWER_ENABLE_N,
   input  wire [CELLS*RW-1:0] CELL_RESULTS,
   input  wire [RW-1:0]       SHIFT_ADD_RESULT,
   output wire [CELLS*CW-1:0] CELL_COEFFICIENTS,
   output wire [CW-1:0]       COEFFICIENT_OUT,
   output wire [RW-1:0]       RESULT_BUS_OUT,
   output wire [RW-1:0]       RESULT_BUS_OE
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function [CW-1:0] tap_pick;
      input [1:0]    sel;
      input [CW-1:0] t0;
      input [CW-1:0] t1;
      input [CW-1:0] t2;
      input [CW-1:0] t3;
      begin
         case (sel)
            `DEC_NONE:  tap_pick = t0;
            `DEC_ONE:   tap_pick = t1;
            `DEC_TWO:   tap_pick = t2;
            `DEC_THREE: tap_pick = t3;
            default:    tap_pick = t0;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // latched controls
   // ----------------------------------------------------------------
   reg  [1:0]    dec_sel_r;
   reg           load_en_r;
   reg  [2:0]    cell_sel_r;
   reg           shift_add_select_r;
   reg  [2:0]    prev_cell_sel_r;
   reg           prev_shift_add_select_r;
   reg           primed_r;

   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         dec_sel_r       <= `DEC_NONE;
         load_en_r       <= 1'b0;
         cell_sel_r      <= 3'h0;
         shift_add_select_r         <= 1'b0;
         prev_cell_sel_r <= 3'h0;
         prev_shift_add_select_r    <= 1'b0;
         primed_r        <= 1'b0;
      end else begin
         dec_sel_r       <= DECIMATION_SELECT;
         load_en_r       <= ~COEFFICIENT_LOAD_ENABLE_N;
         cell_sel_r      <= CELL_SELECT;
         shift_add_select_r         <= SHIFT_ADD_SELECT;
         prev_cell_sel_r <= cell_sel_r;
         prev_shift_add_select_r    <= shift_add_select_r;
         primed_r        <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // coefficient path: C register then three decimation registers
   // ----------------------------------------------------------------
   reg  [CW-1:0] c_r  [0:CELLS-1];
   reg  [CW-1:0] d1_r [0:CELLS-1];
   reg  [CW-1:0] d2_r [0:CELLS-1];
   reg  [CW-1:0] d3_r [0:CELLS-1];
   reg  [CW-1:0] coef_out_r;
   wire [CW-1:0] cell_out [0:CELLS-1];
   wire [CW-1:0] last_in;
   integer       i;

   genvar g;
   generate
      for (g = 0; g < CELLS; g = g + 1) begin : taps
         // exit point set by the latched decimation code
         assign cell_out[g] = tap_pick(dec_sel_r, c_r[g], d1_r[g], d2_r[g], d3_r[g]);
         assign CELL_COEFFICIENTS[g*CW +: CW] = c_r[g];
      end
   endgenerate

   assign last_in = (CELLS > 1) ? cell_out[CELLS-2] : COEFFICIENT_IN;

   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         for (i = 0; i < CELLS; i = i + 1) begin
            c_r[i]  <= {CW{1'b0}};
            d1_r[i] <= {CW{1'b0}};
            d2_r[i] <= {CW{1'b0}};
            d3_r[i] <= {CW{1'b0}};
         end
         coef_out_r <= {CW{1'b0}};
      end else if (load_en_r) begin
         c_r[0] <= COEFFICIENT_IN;
         for (i = 1; i < CELLS; i = i + 1) begin
            c_r[i]  <= cell_out[i-1];
         end
         for (i = 0; i < CELLS; i = i + 1) begin
            d1_r[i] <= c_r[i];
            d2_r[i] <= d1_r[i];
            d3_r[i] <= d2_r[i];
         end
         // shadow of the last cell's exit tap so the pin comes from a flop
         coef_out_r <= tap_pick(dec_sel_r, last_in, c_r[CELLS-1], d1_r[CELLS-1], d2_r[CELLS-1]);
      end
   end

   assign COEFFICIENT_OUT = coef_out_r;

   // ----------------------------------------------------------------
   // result capture
   // ----------------------------------------------------------------
   // a word is captured on the first clock after reset, then only when the latched selection changes, so an
   // unchanged address keeps the first clock's value for slow readers
   reg           pend_r;
   reg  [RW-1:0] pend_word_r;
   wire          sel_changed;
   wire [RW-1:0] sel_word;
   wire          fifo_in_ready;
   wire          fifo_out_valid;
   wire [RW-1:0] fifo_out_data;
   wire          drain_ok;

   assign sel_changed = ~primed_r | (cell_sel_r != prev_cell_sel_r) | (shift_add_select_r != prev_shift_add_select_r);
   assign sel_word    = shift_add_select_r ? SHIFT_ADD_RESULT : CELL_RESULTS[cell_sel_r*RW +: RW];

   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         pend_r      <= 1'b0;
         pend_word_r <= {RW{1'b0}};
      end else if (sel_changed) begin
         // a newer selection replaces one still waiting for room
         pend_r      <= 1'b1;
         pend_word_r <= sel_word;
      end else if (fifo_in_ready) begin
         pend_r      <= 1'b0;
      end
   end

   result_fifo #(
      .WIDTH (RW),
      .DEPTH (`RESULT_FIFO_DEPTH),
      .AW    (`RESULT_FIFO_AW)
   ) u_fifo (
      .clk       (CLOCK),
      .rst_n     (RSTN),
      .in_valid  (pend_r),
      .in_ready  (fifo_in_ready),
      .in_data   (pend_word_r),
      .out_valid (fifo_out_valid),
      .out_ready (drain_ok),
      .out_data  (fifo_out_data)
   );

   // ----------------------------------------------------------------
   // result bus drive
   // ----------------------------------------------------------------
   // a half-read in progress freezes the word so both halves match
   reg  [RW-1:0] result_r;
   reg  [RW-1:0] oe_r;

   assign drain_ok = (RESULT_UPPER_ENABLE_N == RESULT_LOWER_ENABLE_N);

   always @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         result_r <= {RW{1'b0}};
         oe_r     <= {RW{1'b0}};
      end else begin
         if (fifo_out_valid && drain_ok) begin
            result_r <= fifo_out_data;
         end
         oe_r[RW-1:`RESULT_HIGH_LSB]  <= {(RW-`RESULT_HIGH_LSB){~RESULT_UPPER_ENABLE_N}};
         oe_r[`RESULT_LOW_MSB:0]      <= {(`RESULT_LOW_MSB+1){~RESULT_LOWER_ENABLE_N}};
      end
   end

   assign RESULT_BUS_OUT = result_r;
   assign RESULT_BUS_OE  = oe_r;

endmodule // fir_decimation_and_result_bus

`default_nettype wire

// >>> verification/fir_dec_properties.sv
`timescale 1ns/100ps
`default_nettype none
module fir_dec_properties #(parameter CELLS = 8, parameter CW = 9, parameter RW = 26) (
   input wire logic                CLOCK,
   input wire logic                RSTN,
   input wire logic [CW-1:0]       COEFFICIENT_IN,
   input wire logic                COEFFICIENT_LOAD_ENABLE_N,
   input wire logic [1:0]          DECIMATION_SELECT,
   input wire logic                RESULT_UPPER_ENABLE_N,
   input wire logic                RESULT_LOWER_ENABLE_N,
   input wire logic [CELLS*CW-1:0] CELL_COEFFICIENTS,
   input wire logic [RW-1:0]       RESULT_BUS_OUT,
   input wire logic [RW-1:0]       RESULT_BUS_OE
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   a_reset_quiet: assert property ($rose(RSTN) |-> RESULT_BUS_OE == 26'h0 && RESULT_BUS_OUT == 26'h0)
      else $error("bus live after reset");
   a_upper_lane_oe: assert property ($past(RSTN) |->
      RESULT_BUS_OE[25:16] == {10{!$past(RESULT_UPPER_ENABLE_N)}}) else $error("upper oe");
   a_lower_lane_oe: assert property ($past(RSTN) |->
      RESULT_BUS_OE[15:0] == {16{!$past(RESULT_LOWER_ENABLE_N)}}) else $error("lower oe");
   a_bus_release: assert property (RESULT_UPPER_ENABLE_N && RESULT_LOWER_ENABLE_N |=> RESULT_BUS_OE == 26'h0)
      else $error("bus not released");
   // one half enabled: the word must sit still between the two halves
   a_split_stall: assert property ((RESULT_UPPER_ENABLE_N != RESULT_LOWER_ENABLE_N) &&
      (RESULT_BUS_OE[25] != RESULT_BUS_OE[0]) |=> $stable(RESULT_BUS_OUT)) else $error("word moved");
   a_coef_frozen: assert property ($past(RSTN, 2) && $past(RSTN) &&
      $past(COEFFICIENT_LOAD_ENABLE_N, 2) |-> $stable(CELL_COEFFICIENTS)) else $error("coef moved");
   a_coef_enter: assert property ($past(RSTN, 2) && $past(RSTN) && !$past(COEFFICIENT_LOAD_ENABLE_N, 2)
      |-> CELL_COEFFICIENTS[8:0] == $past(COEFFICIENT_IN)) else $error("coef not loaded");
   a_plain_hop: assert property ($past(RSTN, 2) && $past(RSTN) && !$past(COEFFICIENT_LOAD_ENABLE_N, 2) &&
      $past(DECIMATION_SELECT, 2) == 2'h0 |-> CELL_COEFFICIENTS[17:9] == $past(CELL_COEFFICIENTS[8:0]))
      else $error("hop mismatch");
endmodule // fir_dec_properties
bind fir_decimation_and_result_bus fir_dec_properties #(.CELLS(CELLS), .CW(CW), .RW(RW)) fir_dec_properties_i (.*);
`default_nettype wire

// >>> verification/host_reader.sv
`timescale 1ns/100ps
`default_nettype none
module host_reader (
   input  wire logic        clk,
   input  wire logic [25:0] bus_out,
   input  wire logic [25:0] bus_oe,
   output var logic         upper_n,
   output var logic         lower_n
);
   // released bits read inverted so a stale word never looks good
   wire [25:0] bus = ~(bus_out ^ bus_oe);
   initial begin
      upper_n = 1'b1;
      lower_n = 1'b1;
   end
   task automatic read_word(input logic split, output logic [25:0] w);
      upper_n <= 1'b0;
      lower_n <= split;
      repeat (3) @(posedge clk);
      w = bus;
      if (split) begin
         upper_n <= 1'b1;
         lower_n <= 1'b0;
         repeat (3) @(posedge clk);
         w[15:0] = bus[15:0];
      end
      upper_n <= 1'b1;
      lower_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   task automatic stall(input int n);
      upper_n <= 1'b0;
      repeat (n) @(posedge clk);
      upper_n <= 1'b1;
   endtask
endmodule // host_reader
`default_nettype wire

// >>> verification/fir_decimation_and_result_bus_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fir_decimation_and_result_bus_tb;
   logic         clk, rstn, load_n, shift_add_select, up_n, lo_n;
   logic [8:0]   cin, cout;
   logic [1:0]   dec;
   logic [2:0]   csel;
   logic [207:0] cres;
   logic [25:0]  sares, rout, roe, w;
   logic [71:0]  coefs;
   int           errors, checked, k;
   fir_decimation_and_result_bus fir_decimation_and_result_bus_i (.CLOCK(clk), .RSTN(rstn),
      .COEFFICIENT_IN(cin), .COEFFICIENT_LOAD_ENABLE_N(load_n), .DECIMATION_SELECT(dec),
      .CELL_SELECT(csel), .SHIFT_ADD_SELECT(shift_add_select), .RESULT_UPPER_ENABLE_N(up_n),
      .RESULT_LOWER_ENABLE_N(lo_n), .CELL_RESULTS(cres), .SHIFT_ADD_RESULT(sares),
      .CELL_COEFFICIENTS(coefs), .COEFFICIENT_OUT(cout), .RESULT_BUS_OUT(rout), .RESULT_BUS_OE(roe));
   host_reader host_reader_i (.clk(clk), .bus_out(rout), .bus_oe(roe), .upper_n(up_n), .lower_n(lo_n));
   // ------
   // helpers
   // ------
   function automatic logic [25:0] cellv(input int n);
      return 26'h1234567 ^ (26'(n) * 26'h0410101);
   endfunction
   task automatic compare(input string what, input logic [71:0] exp, input logic [71:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic hop(input int lo, output int n);
      n = 0;
      while (coefs[lo +: 9] !== 9'h0A5 && n < 20) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic final_report;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      $display("[FAIL] watchdog expected done seen hang");
      final_report;
   end
   initial begin
      {rstn, load_n, shift_add_select, cin, dec, csel} = 17'h0;
      sares = 26'h2AAAAAA;
      for (int n = 0; n < 8; n++) cres[n*26 +: 26] = cellv(n);
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      compare("oe after reset", 72'h0, roe);
      for (int n = 0; n < 8; n++) begin
         csel <= 3'(n);
         repeat (6) @(posedge clk);
         host_reader_i.read_word(1'(n), w);
         compare("cell word", cellv(n), w);
      end
      $display("test cell_select done");
      cres <= ~cres;
      repeat (6) @(posedge clk);
      host_reader_i.read_word(1'b0, w);
      compare("held word", cellv(7), w);
      shift_add_select <= 1'b1;
      repeat (6) @(posedge clk);
      sares <= 26'h0;
      repeat (4) @(posedge clk);
      host_reader_i.read_word(1'b0, w);
      compare("adder word", 26'h2AAAAAA, w);
      $display("test hold done");
      cres <= ~cres;
      // ten selections while half the bus is held overrun the eight-word buffer
      fork
         host_reader_i.stall(30);
         for (int n = 0; n < 10; n++) begin
            {shift_add_select, csel} <= {1'b0, 3'(n)};
            repeat (2) @(posedge clk);
         end
      join
      repeat (14) @(posedge clk);
      host_reader_i.read_word(1'b0, w);
      compare("drained word", cellv(1), w);
      $display("test stall done");
      for (int d = 0; d < 4; d++) begin
         dec <= 2'(d);
         repeat (12) @(posedge clk);
         cin <= 9'h0A5;
         @(posedge clk);
         cin <= 9'h0;
         hop(0, k);
         hop(9, k);
         compare("hop cycles", d + 1, k);
      end
      repeat (40) @(posedge clk);
      load_n <= 1'b1;
      @(posedge clk);
      cin <= 9'h1FF;
      repeat (20) @(posedge clk);
      compare("frozen coef", 72'h0, coefs);
      compare("frozen exit", 72'h0, cout);
      $display("test coefficient done");
      final_report;
   end
endmodule // fir_decimation_and_result_bus_tb
`default_nettype wire
